// *** design/window_pkg.sv ***
// Constants and types shared by the program-space window logic
package window_pkg;
    // Control-register region bounds
    localparam logic [15:0] SFR_FIRST = 16'h0000;
    localparam logic [15:0] SFR_LAST = 16'h07ff;
    // Page register offsets and reset values
    localparam logic [15:0] OFS_READ_PAGE = 16'h0032;
    localparam logic [15:0] OFS_WRITE_PAGE = 16'h0034;
    localparam logic [15:0] READ_PAGE_RESET = 16'h0000;
    localparam logic [15:0] WRITE_PAGE_RESET = 16'h0000;
    // Field positions
    localparam int EA_WINDOW_BIT = 15;
    localparam int PAGE_PROG_BIT = 9;
    localparam int PAGE_UPPER_BIT = 8;
    localparam int PAGE_LOW_MSB = 7;
    localparam int EA_OFS_MSB = 14;
    localparam int PROG_ADDR_W = 23;
    // Extra instruction cycles for window reads
    localparam logic [1:0] EXTRA_NONE = 2'h0;
    localparam logic [1:0] EXTRA_MOV = 2'h1;
    localparam logic [1:0] EXTRA_OTHER = 2'h2;
    localparam logic [1:0] EXTRA_REPEAT_EDGE = 2'h2;
    // Access classes out of the decoder
    typedef enum logic [2:0] {
        ACC_RAM,
        ACC_SFR,
        ACC_PAGE_REG,
        ACC_PROG,
        ACC_TRAP
    } access_e;
endpackage

// *** design/window_decode.sv ***
// Address decoder and program address builder for the data window
`timescale 1ns/1ps
module window_decode (
    input wire logic [15:0] addr,
    input wire logic write,
    input wire logic [15:0] read_page,
    input wire logic [15:0] write_page,
    output window_pkg::access_e access,
    output logic [window_pkg::PROG_ADDR_W-1:0] prog_addr
);
    import window_pkg::*;

    // Classify one access; traps take precedence over every other route
    always_comb begin
        access = ACC_RAM;
        if (addr[EA_WINDOW_BIT]) begin
            if (write) begin
                access = (write_page == 16'h0000) ? ACC_TRAP : ACC_RAM;
            end else if (read_page == 16'h0000) begin
                access = ACC_TRAP;
            end else if (read_page[PAGE_PROG_BIT]) begin
                access = ACC_PROG;
            end
        end else if (addr >= SFR_FIRST && addr <= SFR_LAST) begin
            access = ((addr[15:1] == OFS_READ_PAGE[15:1]) || (addr[15:1] == OFS_WRITE_PAGE[15:1]))
                ? ACC_PAGE_REG : ACC_SFR;
        end
    end

    // Page low byte over word offset; page bit 8 picks the even or odd word
    assign prog_addr = {read_page[PAGE_LOW_MSB:0], addr[EA_OFS_MSB:1],
                        read_page[PAGE_UPPER_BIT]};
endmodule

// *** design/window_cost.sv ***
// Extra instruction cycles charged for a read through the program window
`timescale 1ns/1ps
module window_cost (
    input wire logic is_move,
    input wire logic in_repeat,
    input wire logic repeat_first,
    input wire logic repeat_last,
    input wire logic repeat_int_exit,
    input wire logic repeat_reentry,
    output logic [1:0] extra
);
    import window_pkg::*;

    // Repeat loops only pay at their edges; steady iterations run in one cycle
    always_comb begin
        if (!in_repeat) begin
            extra = is_move ? EXTRA_MOV : EXTRA_OTHER;
        end else if (repeat_first || repeat_last || repeat_int_exit || repeat_reentry) begin
            extra = EXTRA_REPEAT_EDGE;
        end else begin
            extra = EXTRA_NONE;
        end
    end
endmodule

// *** design/data_to_program_space_window.sv ***
// Data-to-program-space window: decode, page registers, flash read path, stalls
`timescale 1ns/1ps
module data_to_program_space_window (
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic REQ_VALID,
    input wire logic REQ_WRITE,
    input wire logic REQ_BYTE,
    input wire logic [15:0] REQ_ADDR,
    input wire logic [15:0] REQ_WDATA,
    input wire logic INSTR_IS_MOVE,
    input wire logic IN_REPEAT,
    input wire logic REPEAT_FIRST,
    input wire logic REPEAT_LAST,
    input wire logic REPEAT_INT_EXIT,
    input wire logic REPEAT_REENTRY,
    input wire logic SFR_IMPL,
    input wire logic [15:0] SFR_RDATA,
    input wire logic [15:0] PROG_RDATA,
    output logic [window_pkg::PROG_ADDR_W-1:0] PROG_ADDR,
    output logic PROG_RD,
    output logic [15:0] RD_DATA,
    output logic RD_VALID,
    output logic SFR_SEL,
    output logic RAM_SEL,
    output logic ADDR_ERR_TRAP,
    output logic [1:0] EXTRA_CYCLES,
    output logic STALL,
    output logic [15:0] READ_PAGE,
    output logic [15:0] WRITE_PAGE
);
    import window_pkg::*;

    typedef struct packed {
        logic [15:0] rpage;
        logic [15:0] wpage;
        logic [PROG_ADDR_W-1:0] prog_addr;
        logic prog_rd;
        logic byte_op;
        logic byte_hi;
        logic [15:0] rd_data;
        logic rd_valid;
        logic sfr_sel;
        logic ram_sel;
        logic trap;
        logic [1:0] extra;
        logic [1:0] stall_cnt;
        logic stall;
    } state_s;

    state_s st;
    state_s next_st;
    logic rst_meta;
    logic rst_n;
    access_e access;
    logic [PROG_ADDR_W-1:0] prog_addr;
    logic [1:0] extra;
    logic [15:0] reg_rdata;
    logic [1:0] stall_dec;

    // Reset is asserted at once but released only after two clean edges
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    window_decode u_decode (
        .addr(REQ_ADDR),
        .write(REQ_WRITE),
        .read_page(st.rpage),
        .write_page(st.wpage),
        .access(access),
        .prog_addr(prog_addr)
    );

    window_cost u_cost (
        .is_move(INSTR_IS_MOVE),
        .in_repeat(IN_REPEAT),
        .repeat_first(REPEAT_FIRST),
        .repeat_last(REPEAT_LAST),
        .repeat_int_exit(REPEAT_INT_EXIT),
        .repeat_reentry(REPEAT_REENTRY),
        .extra(extra)
    );

    // Read mux for the control-register region; holes return zero
    always_comb begin
        if (access == ACC_PAGE_REG) begin
            reg_rdata = (REQ_ADDR[15:1] == OFS_READ_PAGE[15:1]) ? st.rpage : st.wpage;
        end else if (SFR_IMPL) begin
            reg_rdata = SFR_RDATA;
        end else begin
            reg_rdata = 16'h0000;
        end
    end

    assign stall_dec = st.stall_cnt - 2'h1;

    // Next-state logic; every pulse output defaults low each cycle
    always_comb begin
        next_st = st;
        next_st.prog_rd = 1'b0;
        next_st.rd_valid = 1'b0;
        next_st.sfr_sel = 1'b0;
        next_st.ram_sel = 1'b0;
        next_st.trap = 1'b0;
        // Stall countdown from the previous window read
        if (st.stall_cnt != 2'h0) begin
            next_st.stall_cnt = stall_dec;
            next_st.stall = (stall_dec != 2'h0);
        end
        // Flash data arrives the cycle after the strobe
        // Limitation: a control-register read taken in that same cycle wins RD_DATA,
        // so the requester must not place one directly behind a window read
        if (st.prog_rd) begin
            next_st.rd_valid = 1'b1;
            next_st.rd_data = st.byte_op
                ? {8'h00, st.byte_hi ? PROG_RDATA[15:8] : PROG_RDATA[7:0]} : PROG_RDATA;
        end
        if (REQ_VALID) begin
            next_st.byte_op = REQ_BYTE;
            next_st.byte_hi = REQ_ADDR[0];
            case (access)
                ACC_RAM: begin
                    next_st.ram_sel = 1'b1;
                end
                ACC_SFR, ACC_PAGE_REG: begin
                    next_st.sfr_sel = 1'b1;
                    if (!REQ_WRITE) begin
                        next_st.rd_valid = 1'b1;
                        next_st.rd_data = REQ_BYTE
                            ? {8'h00, REQ_ADDR[0] ? reg_rdata[15:8] : reg_rdata[7:0]}
                            : reg_rdata;
                    end else if (access == ACC_PAGE_REG) begin
                        // Byte writes touch only the addressed lane
                        if (REQ_ADDR[15:1] == OFS_READ_PAGE[15:1]) begin
                            if (!REQ_BYTE || !REQ_ADDR[0]) next_st.rpage[7:0] = REQ_WDATA[7:0];
                            if (!REQ_BYTE || REQ_ADDR[0]) begin
                                next_st.rpage[15:8] = REQ_BYTE ? REQ_WDATA[7:0] : REQ_WDATA[15:8];
                            end
                        end else begin
                            if (!REQ_BYTE || !REQ_ADDR[0]) next_st.wpage[7:0] = REQ_WDATA[7:0];
                            if (!REQ_BYTE || REQ_ADDR[0]) begin
                                next_st.wpage[15:8] = REQ_BYTE ? REQ_WDATA[7:0] : REQ_WDATA[15:8];
                            end
                        end
                    end
                end
                ACC_PROG: begin
                    // Only reads reach here; writes never route to flash
                    next_st.prog_rd = 1'b1;
                    next_st.prog_addr = prog_addr;
                    next_st.extra = extra;
                    next_st.stall_cnt = extra;
                    next_st.stall = (extra != 2'h0);
                end
                ACC_TRAP: begin
                    next_st.trap = 1'b1;
                end
                default: begin
                    next_st.ram_sel = 1'b0;
                end
            endcase
        end
    end

    // Whole block state in one register
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.rpage <= READ_PAGE_RESET;
            st.wpage <= WRITE_PAGE_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign PROG_ADDR = st.prog_addr;
    assign PROG_RD = st.prog_rd;
    assign RD_DATA = st.rd_data;
    assign RD_VALID = st.rd_valid;
    assign SFR_SEL = st.sfr_sel;
    assign RAM_SEL = st.ram_sel;
    assign ADDR_ERR_TRAP = st.trap;
    assign EXTRA_CYCLES = st.extra;
    assign STALL = st.stall;
    assign READ_PAGE = st.rpage;
    assign WRITE_PAGE = st.wpage;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!rst_n);

    a_sfr_hole_zero: assert property (
        REQ_VALID && !REQ_WRITE && access == ACC_SFR && !SFR_IMPL
        |=> RD_VALID && RD_DATA == 16'h0000 && SFR_SEL)
        else $error("Unimplemented control register did not read zero");

    a_sfr_region: assert property (
        REQ_VALID && REQ_ADDR <= SFR_LAST |=> SFR_SEL && !RAM_SEL && !PROG_RD)
        else $error("Control-register region not decoded");

    a_prog_route: assert property (
        REQ_VALID && !REQ_WRITE && REQ_ADDR[15] && st.rpage[9] |=> PROG_RD ##1 RD_VALID)
        else $error("Window read not routed to program memory");

    a_low_half_plain: assert property (
        REQ_VALID && !REQ_ADDR[15] |=> !PROG_RD && !ADDR_ERR_TRAP && !STALL)
        else $error("Lower-half access used the window");

    a_prog_page_bits: assert property (
        REQ_VALID && !REQ_WRITE && REQ_ADDR[15] && st.rpage[9]
        |=> PROG_ADDR[22:15] == $past(st.rpage[7:0]) && PROG_ADDR[14:1] == $past(REQ_ADDR[14:1]))
        else $error("Program address fields wrong");

    a_word_select: assert property (
        REQ_VALID && !REQ_WRITE && REQ_ADDR[15] && st.rpage[9]
        |=> PROG_ADDR[0] == $past(st.rpage[8]))
        else $error("Upper or lower word selection wrong");

    a_write_no_flash: assert property (
        REQ_VALID && REQ_WRITE && REQ_ADDR[15] |=> !PROG_RD)
        else $error("Write routed to program memory");

    a_zero_page_trap: assert property (
        REQ_VALID && REQ_ADDR[15] && (REQ_WRITE ? st.wpage == 16'h0000 : st.rpage == 16'h0000)
        |=> ADDR_ERR_TRAP && !PROG_RD && !RAM_SEL)
        else $error("Zero page access did not trap");

    a_move_one_cycle: assert property (
        REQ_VALID && access == ACC_PROG && !IN_REPEAT && INSTR_IS_MOVE |=> STALL ##1 !STALL)
        else $error("Move outside repeat not charged one cycle");

    a_repeat_edge_two: assert property (
        REQ_VALID && access == ACC_PROG && IN_REPEAT && REPEAT_FIRST
        |=> STALL && EXTRA_CYCLES == 2'h2 ##1 STALL ##1 !STALL)
        else $error("Repeat edge not charged two cycles");

    a_repeat_steady: assert property (
        REQ_VALID && access == ACC_PROG && IN_REPEAT && !REPEAT_FIRST && !REPEAT_LAST
        && !REPEAT_INT_EXIT && !REPEAT_REENTRY && !STALL |=> !STALL)
        else $error("Steady repeat iteration stalled");

    a_page_write: assert property (
        REQ_VALID && REQ_WRITE && !REQ_BYTE && REQ_ADDR == OFS_READ_PAGE
        |=> READ_PAGE == $past(REQ_WDATA))
        else $error("Read page register not written");

    // Word parity, cost classes, open write page and the read answers
    a_lower_word_even: assert property (
        REQ_VALID && !REQ_WRITE && REQ_ADDR[EA_WINDOW_BIT] && st.rpage[PAGE_PROG_BIT]
        && !st.rpage[PAGE_UPPER_BIT] |=> PROG_RD && !PROG_ADDR[0])
        else $error("Lower-word page gave an odd program address");

    a_upper_word_odd: assert property (
        REQ_VALID && !REQ_WRITE && REQ_ADDR[EA_WINDOW_BIT] && st.rpage[PAGE_PROG_BIT]
        && st.rpage[PAGE_UPPER_BIT] |=> PROG_RD && PROG_ADDR[0])
        else $error("Upper-word page gave an even program address");

    a_other_two_cycles: assert property (
        REQ_VALID && access == ACC_PROG && !IN_REPEAT && !INSTR_IS_MOVE
        |=> STALL && EXTRA_CYCLES == EXTRA_OTHER ##1 STALL ##1 !STALL)
        else $error("Non-move outside repeat not charged two cycles");

    a_repeat_exit_two: assert property (
        REQ_VALID && access == ACC_PROG && IN_REPEAT
        && (REPEAT_LAST || REPEAT_INT_EXIT || REPEAT_REENTRY)
        |=> STALL && EXTRA_CYCLES == EXTRA_REPEAT_EDGE ##1 STALL ##1 !STALL)
        else $error("Repeat exit or re-entry not charged two cycles");

    a_steady_no_extra: assert property (
        REQ_VALID && access == ACC_PROG && IN_REPEAT && !REPEAT_FIRST && !REPEAT_LAST
        && !REPEAT_INT_EXIT && !REPEAT_REENTRY |=> EXTRA_CYCLES == EXTRA_NONE && !STALL)
        else $error("Steady repeat iteration charged extra cycles");

    a_write_page_open: assert property (
        REQ_VALID && REQ_WRITE && REQ_ADDR[EA_WINDOW_BIT] && st.wpage != 16'h0000
        |=> RAM_SEL && !ADDR_ERR_TRAP && !PROG_RD)
        else $error("Write with a nonzero write page trapped");

    a_flash_answer: assert property (
        PROG_RD && !st.byte_op
        && !(REQ_VALID && !REQ_WRITE && (access == ACC_SFR || access == ACC_PAGE_REG))
        |=> RD_VALID && RD_DATA == $past(PROG_RDATA))
        else $error("Flash word not returned on the read answer");

    a_sfr_word_read: assert property (
        REQ_VALID && !REQ_WRITE && !REQ_BYTE && access == ACC_SFR && SFR_IMPL
        |=> RD_VALID && SFR_SEL && RD_DATA == $past(SFR_RDATA))
        else $error("Control register read data not returned");

    a_low_half_ram: assert property (
        REQ_VALID && !REQ_ADDR[EA_WINDOW_BIT] && REQ_ADDR > SFR_LAST |=> RAM_SEL && !SFR_SEL)
        else $error("Lower-half data access not sent to RAM");
endmodule

// *** tb/flash_model.sv ***
// Behavioural program flash answering the window read strobe
`timescale 1ns/1ps
module flash_model (
    input wire logic clk,
    input wire logic rd,
    input wire logic [22:0] addr,
    output logic [15:0] data
);
    logic [15:0] last = 16'h0000;
    logic [15:0] word;
    // Content follows the address so a wrong address gives wrong data
    assign word = addr[15:0] ^ {addr[22:15], 8'ha5};
    // Idle bus shows the inverse of the last word, so stale data never matches
    assign data = rd ? word : ~last;
    // Remember the last word driven
    always @(posedge clk) begin
        if (rd) begin
            last <= word;
        end
    end
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the program-space window block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb;
    import window_pkg::*;
    logic CLK_SYS = 0, RESET_N = 0, REQ_VALID = 0, REQ_WRITE = 0, REQ_BYTE = 0;
    logic [15:0] REQ_ADDR = 0, REQ_WDATA = 0, SFR_RDATA = 0, PROG_RDATA;
    logic INSTR_IS_MOVE = 1, IN_REPEAT = 0, REPEAT_FIRST = 0, REPEAT_LAST = 0;
    logic REPEAT_INT_EXIT = 0, REPEAT_REENTRY = 0, SFR_IMPL = 0;
    logic [PROG_ADDR_W-1:0] PROG_ADDR;
    logic PROG_RD, RD_VALID, SFR_SEL, RAM_SEL, ADDR_ERR_TRAP, STALL;
    logic [15:0] RD_DATA, READ_PAGE, WRITE_PAGE;
    logic [1:0] EXTRA_CYCLES;
    int err_total = 0, n_tests = 0;
    logic [7:0] cost_tab [8] = '{8'h81, 8'h02, 8'h40, 8'h62, 8'h52, 8'h4a, 8'h46, 8'hc0};

    data_to_program_space_window dut_u (.*);
    flash_model flash_u (.clk(CLK_SYS), .rd(PROG_RD), .addr(PROG_ADDR), .data(PROG_RDATA));

    // Free-running 200 MHz clock
    initial begin
        forever #2.5 CLK_SYS = ~CLK_SYS;
    end

    // Bench copy of the flash contents
    function automatic logic [15:0] fdat(input logic [22:0] a);
        return a[15:0] ^ {a[22:15], 8'ha5};
    endfunction

    // One access; returns in the cycle after the request was taken
    task automatic req(input logic w, input logic b, input logic [15:0] a, input logic [15:0] d);
        @(negedge CLK_SYS);
        REQ_VALID = 1;
        REQ_WRITE = w;
        REQ_BYTE = b;
        REQ_ADDR = a;
        REQ_WDATA = d;
        @(negedge CLK_SYS);
        REQ_VALID = 0;
    endtask

    // Select a page and read through the window, checking address, cost and data
    task automatic win(input logic [15:0] pg, input logic [15:0] ea, input logic [1:0] ex);
        logic [22:0] pa;
        pa = {pg[7:0], ea[14:0]};
        pa[0] = pg[8];
        req(1, 0, 16'h0032, pg);
        req(0, 0, ea, 16'h0000);
        `CHK("prog_rd", 1'b1, PROG_RD)
        `CHK("prog_addr", pa, PROG_ADDR)
        `CHK("word_sel", pg[8], PROG_ADDR[0])
        `CHK("extra", ex, EXTRA_CYCLES)
        `CHK("stall", ex != 2'h0, STALL)
        @(negedge CLK_SYS);
        `CHK("rd_valid", 1'b1, RD_VALID)
        `CHK("rd_data", fdat(pa), RD_DATA)
        `CHK("stall_len", ex == 2'h2, STALL)
        repeat (4) if (STALL !== 1'b0) @(negedge CLK_SYS);
    endtask

    task automatic t_regs;
        `CHK("rpage_rst", 16'h0000, READ_PAGE)
        `CHK("wpage_rst", 16'h0000, WRITE_PAGE)
        req(1, 0, 16'h0032, 16'h0202);
        `CHK("page_sel", 1'b1, SFR_SEL)
        `CHK("rpage", 16'h0202, READ_PAGE)
        req(1, 1, 16'h0033, 16'h0003);
        `CHK("rpage_hi", 16'h0302, READ_PAGE)
        req(0, 0, 16'h0032, 16'h0000);
        `CHK("rpage_rd", 16'h0302, RD_DATA)
        req(0, 1, 16'h0033, 16'h0000);
        `CHK("rpage_byte", 16'h0003, RD_DATA)
    endtask

    task automatic t_sfr;
        req(0, 0, 16'h0700, 16'h0000);
        `CHK("hole_valid", 1'b1, RD_VALID)
        `CHK("hole_data", 16'h0000, RD_DATA)
        SFR_IMPL = 1;
        SFR_RDATA = 16'h1234;
        req(0, 0, 16'h07fe, 16'h0000);
        `CHK("sfr_sel", 1'b1, SFR_SEL)
        `CHK("sfr_data", 16'h1234, RD_DATA)
        SFR_IMPL = 0;
        req(0, 0, 16'h0800, 16'h0000);
        `CHK("ram_edge", 1'b1, RAM_SEL)
        `CHK("sfr_edge", 1'b0, SFR_SEL)
    endtask

    // Both page ends, both word halves, both window ends
    task automatic t_window;
        logic [15:0] pgs [4] = '{16'h0200, 16'h02ff, 16'h0300, 16'h03ff};
        logic [22:0] lo_ad [4] = '{23'h000000, 23'h7f8000, 23'h000001, 23'h7f8001};
        logic [22:0] hi_ad [4] = '{23'h007ffe, 23'h7ffffe, 23'h007fff, 23'h7fffff};
        foreach (pgs[i]) begin
            win(pgs[i], 16'h8000, 2'h1);
            `CHK("tab_lo", lo_ad[i], PROG_ADDR)
            win(pgs[i], 16'hfffe, 2'h1);
            `CHK("tab_hi", hi_ad[i], PROG_ADDR)
        end
        req(1, 0, 16'h0032, 16'h0202);
        req(0, 1, 16'h800b, 16'h0000);
        @(negedge CLK_SYS);
        `CHK("byte_hi", 16'h0002, RD_DATA)
        req(1, 0, 16'h0032, 16'h01ff);
        req(0, 0, 16'h8004, 16'h0000);
        `CHK("nobit9_ram", 1'b1, RAM_SEL)
        `CHK("nobit9_rd", 1'b0, PROG_RD)
        req(1, 0, 16'h0032, 16'h0300);
        req(0, 0, 16'h7ffe, 16'h0000);
        `CHK("low_ram", 1'b1, RAM_SEL)
        `CHK("low_rd", 1'b0, PROG_RD)
    endtask

    task automatic t_trap;
        req(1, 0, 16'h0032, 16'h0000);
        req(0, 0, 16'h8000, 16'h0000);
        `CHK("rd_trap", 1'b1, ADDR_ERR_TRAP)
        `CHK("rd_trap_rd", 1'b0, PROG_RD)
        req(1, 0, 16'h0032, 16'h0300);
        req(1, 0, 16'hc000, 16'h5555);
        `CHK("wr_trap", 1'b1, ADDR_ERR_TRAP)
        req(1, 0, 16'h0034, 16'h0001);
        `CHK("wpage", 16'h0001, WRITE_PAGE)
        req(1, 0, 16'hc000, 16'h5555);
        `CHK("wr_notrap", 1'b0, ADDR_ERR_TRAP)
        `CHK("wr_noflash", 1'b0, PROG_RD)
        `CHK("wr_ram", 1'b1, RAM_SEL)
    endtask

    // Every cost class: move or not, inside repeat with each edge qualifier
    task automatic t_cost;
        foreach (cost_tab[i]) begin
            {INSTR_IS_MOVE, IN_REPEAT, REPEAT_FIRST, REPEAT_LAST} = cost_tab[i][7:4];
            {REPEAT_INT_EXIT, REPEAT_REENTRY} = cost_tab[i][3:2];
            win(16'h0202, 16'h800a, cost_tab[i][1:0]);
        end
    endtask

    // Mid-run reset: pages return to zero and a window read traps again
    task automatic t_reset;
        @(negedge CLK_SYS);
        RESET_N = 0;
        @(negedge CLK_SYS);
        `CHK("rst_rpage", 16'h0000, READ_PAGE)
        `CHK("rst_wpage", 16'h0000, WRITE_PAGE)
        RESET_N = 1;
        repeat (3) @(negedge CLK_SYS);
        req(0, 0, 16'h8000, 16'h0000);
        `CHK("rst_trap", 1'b1, ADDR_ERR_TRAP)
    endtask

    // Steady repeat iterations issue window reads on consecutive cycles
    task automatic t_burst;
        {INSTR_IS_MOVE, IN_REPEAT, REPEAT_FIRST, REPEAT_LAST} = 4'h4;
        {REPEAT_INT_EXIT, REPEAT_REENTRY} = 2'h0;
        req(1, 0, 16'h0032, 16'h0202);
        @(negedge CLK_SYS);
        REQ_VALID = 1;
        REQ_WRITE = 0;
        REQ_ADDR = 16'h800a;
        @(negedge CLK_SYS);
        REQ_ADDR = 16'h800c;
        @(negedge CLK_SYS);
        REQ_VALID = 0;
        `CHK("burst_addr", 23'h01000c, PROG_ADDR)
        `CHK("burst_stall", 1'b0, STALL)
        `CHK("burst_valid1", 1'b1, RD_VALID)
        `CHK("burst_rd1", fdat(23'h01000a), RD_DATA)
        @(negedge CLK_SYS);
        `CHK("burst_valid2", 1'b1, RD_VALID)
        `CHK("burst_rd2", fdat(23'h01000c), RD_DATA)
    endtask

    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Main sequence: reset for six cycles, wait out the synchroniser, then run
    initial begin
        repeat (6) @(negedge CLK_SYS);
        RESET_N = 1;
        repeat (3) @(negedge CLK_SYS);
        t_regs;
        t_sfr;
        t_window;
        t_trap;
        t_reset;
        t_cost;
        t_burst;
        end_sim;
    end

    // Watchdog well beyond the roughly 150 cycles the tests need
    initial begin
        #50us;
        err_total++;
        end_sim;
    end
endmodule
